// File: design/acs_pkg.sv
// shared constants, field layout and state type of the conversion sequencer
package acs_pkg;
    // register bus geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int RES_W = 10;
    localparam int CH_W = 4;
    localparam int NUM_CH = 16;

    // register word addresses
    localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_INJRES = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_INJCTL = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_MASK = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_DIGIN = 3'h6;

    // converter control register fields
    localparam int CTL_CHAN_LSB = 0;
    localparam int CTL_MODE_LSB = 4;
    localparam int CTL_START_BIT = 6;
    localparam int CTL_WFR_BIT = 7;
    localparam int CTL_SUSP_BIT = 8;
    localparam int CTL_SC_LSB = 12;
    localparam int CTL_CC_LSB = 14;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

    // injection control and result layout
    localparam int INJ_REQ_BIT = 4;
    localparam int RES_CH_LSB = 12;

    // status and mask bits
    localparam int STAT_W = 3;
    localparam int ST_DONE = 0;
    localparam int ST_OVR = 1;
    localparam int ST_INJ = 2;

    // conversion modes
    localparam logic [1:0] MODE_SGL_ONE = 2'h0;
    localparam logic [1:0] MODE_SGL_CONT = 2'h1;
    localparam logic [1:0] MODE_SCAN_ONE = 2'h2;
    localparam logic [1:0] MODE_SCAN_CONT = 2'h3;

    // timing: base clock phase is one system clock of 5 ns
    localparam int SYS_CLK_PS = 5000;
    localparam int TCL_PS = 5000;
    localparam int TCL_CYCLES = (TCL_PS + SYS_CLK_PS - 1) / SYS_CLK_PS;
    localparam int PER_W = 8;
    localparam logic [PER_W-1:0] CC_MUL_00 = 8'h18;
    localparam logic [PER_W-1:0] CC_MUL_10 = 8'h60;
    localparam logic [PER_W-1:0] CC_MUL_11 = 8'h30;
    localparam logic [3:0] CONV_PERIODS = 4'hA;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_HOLD}
        acs_state_t;
endpackage

// File: design/acs_cc_tick.sv
// conversion clock tick generator, one pulse per programmed period
`timescale 1ns/1ps
`default_nettype none
module acs_cc_tick
    import acs_pkg::*;
#(
    parameter int PW = PER_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control
    input wire logic en,
    input wire logic [PW-1:0] period,
    // tick out
    output logic tick
);
    logic [PW-1:0] cnt_q;
    logic [PW-1:0] since_q;
    wire wrap = (cnt_q == period - PW'(1));

    // counter restarts whenever the phase logic drops the enable
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= (!en || wrap) ? '0 : cnt_q + PW'(1);
            tick <= en && wrap;
        end
    end

    // helper: cycles since the last tick, for the period check
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            since_q <= '0;
        end else begin
            since_q <= !en ? '0 : (tick ? PW'(1) : since_q + PW'(1));
        end
    end

    AST_CC_PERIOD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (en && tick && $past(en) && $stable(period) && since_q != '0)
        |-> ($past(since_q) == period - PW'(1)))
        else $error("conversion clock period wrong");
endmodule
`default_nettype wire

// File: design/acs_result_buf.sv
// temporary result holding register used while a conversion waits for a read
`timescale 1ns/1ps
`default_nettype none
module acs_result_buf
    import acs_pkg::*;
#(
    parameter int W = DATA_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // fill side
    input wire logic load,
    input wire logic [W-1:0] din,
    // drain side
    input wire logic drain,
    output logic full,
    output logic [W-1:0] dout
);
    // one entry; a drain and a load never coincide in the sequencer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            full <= 1'b0;
            dout <= '0;
        end else begin
            if (load) begin
                dout <= din;
            end
            full <= load ? 1'b1 : (drain ? 1'b0 : full);
        end
    end
endmodule
`default_nettype wire

// File: design/acs_seq_top.sv
// conversion sequencer: modes, overrun, wait-for-read, injection, registers
//
// Notes on behaviour
// - 10-bit results, channel chosen from 16
// - overrun raises flag, or suspends until read
// - channel pins stay readable as digital inputs
// - single mode: convert once, store, stop
// - continuous single: repeat same channel until stopped
// - scan single: each selected channel once, store each
// - scan continuous: cycle selected channels without end
// - every stored result raises a service request
// - wait-for-read: buffer result, pause until read (the code does this in the continuous modes only; single modes flag an overrun)
// - injected conversion goes to injection result register
// - after injection, continuous mode resumes unchanged
// - conversion clock 24, 96, 48 base phases
// - clock selects at 15:14, sample 13:12
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module acs_seq_top
    import acs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [DATA_W-1:0] regRdData,
    // analog front end
    input wire logic [RES_W-1:0] convData,
    input wire logic [NUM_CH-1:0] anaDigIn,
    output logic [CH_W-1:0] muxSel,
    output logic sampleEn,
    output logic convEn,
    // status
    output logic busy,
    output logic irq
);
    acs_state_t state_q, state_d;
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] result_q;
    logic [DATA_W-1:0] injResult_q;
    logic [CH_W-1:0] injChan_q;
    logic [CH_W-1:0] chan_q, chan_d;
    logic [3:0] cnt_q, cnt_d;
    logic [STAT_W-1:0] status_q, mask_q;
    logic [NUM_CH-1:0] digIn_q;
    logic unread_q, run_q, run_d, injAct_q, injAct_d, injPend_q, injPend_d;
    logic enterSample;
    logic ccTick, bufFull;
    logic [DATA_W-1:0] bufData;

    // all checks below run on the system clock, off during reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // register decode
    wire wrCtl = regWrEn && (regAddr == OFS_CTRL);
    wire wrInj = regWrEn && (regAddr == OFS_INJCTL);
    wire wrStat = regWrEn && (regAddr == OFS_STATUS);
    wire wrMask = regWrEn && (regAddr == OFS_MASK);
    wire rdResult = regRdEn && (regAddr == OFS_RESULT);

    // control fields
    wire [1:0] mode = ctrl_q[CTL_MODE_LSB +: 2];
    wire [CH_W-1:0] startChan = ctrl_q[CTL_CHAN_LSB +: CH_W];
    wire [1:0] ccSel = ctrl_q[CTL_CC_LSB +: 2];
    wire [1:0] scSel = ctrl_q[CTL_SC_LSB +: 2];
    wire contMode = mode[0];
    wire scanMode = mode[1];

    // conversion clock period; reserved code 01 falls back to 24 phases
    wire [PER_W-1:0] ccMul = (ccSel == 2'h2) ? CC_MUL_10 :
                             (ccSel == 2'h3) ? CC_MUL_11 : CC_MUL_00;
    wire [PER_W-1:0] ccPeriod = PER_W'(ccMul * PER_W'(TCL_CYCLES));
    // sample period of 1, 2, 4 or 8 conversion clocks
    wire [3:0] sampleLast = (4'h1 << scSel) - 4'h1;

    // phase completion and result routing
    wire convLast = (state_q == ST_CONVERT) && ccTick &&
                    (cnt_q == CONV_PERIODS - 4'h1);
    wire doneInj = convLast && injAct_q;
    wire doneNorm = convLast && !injAct_q;
    // suspension, or wait-for-read in a continuous mode, parks the result
    wire holdSel = ctrl_q[CTL_SUSP_BIT] |
                   (ctrl_q[CTL_WFR_BIT] & contMode);
    wire goHold = doneNorm && unread_q && holdSel;
    wire fromHold = (state_q == ST_HOLD) && rdResult;
    wire loadRes = (doneNorm && !goHold) || fromHold;
    wire overrun = doneNorm && unread_q && !holdSel;
    // run flag before any store this cycle; reading run_d would loop
    wire runKeep = run_q && !(wrCtl && !regWrData[CTL_START_BIT]);
    wire stopNow = !runKeep || (mode == MODE_SGL_ONE) ||
                   ((mode == MODE_SCAN_ONE) && (chan_q == '0));
    // scan walks down from the start channel to channel 0
    wire [CH_W-1:0] nextChan = !scanMode ? chan_q :
        ((chan_q == '0) ? startChan : chan_q - CH_W'(1));
    wire [DATA_W-1:0] newRes = {chan_q, 2'h0, convData};
    wire [DATA_W-1:0] resIn = fromHold ? bufData : newRes;
    wire [STAT_W-1:0] statSet = {doneInj, overrun, loadRes};

    acs_cc_tick #(.PW(PER_W)) u_tick (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .en((state_q == ST_SAMPLE) || (state_q == ST_CONVERT)),
        .period(ccPeriod),
        .tick(ccTick)
    );

    acs_result_buf #(.W(DATA_W)) u_buf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .load(goHold),
        .din(newRes),
        .drain(fromHold),
        .full(bufFull),
        .dout(bufData)
    );

    // sequencer next state
    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        cnt_d = cnt_q;
        run_d = run_q;
        injAct_d = injAct_q;
        injPend_d = injPend_q;
        enterSample = 1'b0;
        if (wrCtl && !regWrData[CTL_START_BIT]) begin
            run_d = 1'b0;
        end
        // injection is only taken while a continuous mode runs
        if (wrInj && regWrData[INJ_REQ_BIT] && run_q && contMode) begin
            injPend_d = 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
                if (wrCtl && regWrData[CTL_START_BIT]) begin
                    run_d = 1'b1;
                    chan_d = regWrData[CTL_CHAN_LSB +: CH_W];
                    enterSample = 1'b1;
                end
            end
            ST_SAMPLE: begin
                if (ccTick) begin
                    if (cnt_q == sampleLast) begin
                        state_d = ST_CONVERT;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            ST_CONVERT: begin
                if (ccTick) begin
                    cnt_d = cnt_q + 4'h1;
                end
                if (doneInj) begin
                    injAct_d = 1'b0;
                    if (run_d) begin
                        enterSample = 1'b1;
                    end else begin
                        state_d = ST_IDLE;
                        injPend_d = 1'b0;
                    end
                end else if (goHold) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                state_d = ST_HOLD;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (loadRes) begin
            if (stopNow) begin
                state_d = ST_IDLE;
                run_d = 1'b0;
                injPend_d = 1'b0;
            end else begin
                chan_d = nextChan;
                enterSample = 1'b1;
            end
        end
        if (enterSample) begin
            state_d = ST_SAMPLE;
            cnt_d = '0;
            injAct_d = injPend_d;
            injPend_d = 1'b0;
        end
    end

    // sequencer state and analog side outputs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            chan_q <= '0;
            cnt_q <= '0;
            run_q <= 1'b0;
            injAct_q <= 1'b0;
            injPend_q <= 1'b0;
            muxSel <= '0;
            sampleEn <= 1'b0;
            convEn <= 1'b0;
            busy <= 1'b0;
        end else begin
            state_q <= state_d;
            chan_q <= chan_d;
            cnt_q <= cnt_d;
            run_q <= run_d;
            injAct_q <= injAct_d;
            injPend_q <= injPend_d;
            muxSel <= injAct_d ? injChan_q : chan_d;
            sampleEn <= (state_d == ST_SAMPLE);
            convEn <= (state_d == ST_CONVERT);
            busy <= (state_d != ST_IDLE);
        end
    end

    // software registers; set beats a same-cycle clear on every flag
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
            injChan_q <= '0;
            mask_q <= '0;
            status_q <= '0;
            unread_q <= 1'b0;
            result_q <= '0;
            injResult_q <= '0;
            digIn_q <= '0;
        end else begin
            if (wrCtl) begin
                ctrl_q <= regWrData & ~(16'h0001 << CTL_START_BIT);
            end
            if (wrInj) begin
                injChan_q <= regWrData[CH_W-1:0];
            end
            if (wrMask) begin
                mask_q <= regWrData[STAT_W-1:0];
            end
            status_q <= statSet |
                (status_q & ~(wrStat ? regWrData[STAT_W-1:0] : '0));
            unread_q <= loadRes | (unread_q & !rdResult);
            if (loadRes) begin
                result_q <= resIn;
            end
            if (doneInj) begin
                injResult_q <= {injChan_q, 2'h0, convData};
            end
            digIn_q <= anaDigIn;
        end
    end

    // read mux; unmapped addresses read zero
    wire [DATA_W-1:0] ctrlView = ctrl_q | (DATA_W'(busy) << CTL_START_BIT);
    wire [DATA_W-1:0] rdMux =
        (regAddr == OFS_CTRL) ? ctrlView :
        (regAddr == OFS_RESULT) ? result_q :
        (regAddr == OFS_INJRES) ? injResult_q :
        (regAddr == OFS_INJCTL) ? DATA_W'(injChan_q) :
        (regAddr == OFS_STATUS) ? DATA_W'(status_q) :
        (regAddr == OFS_MASK) ? DATA_W'(mask_q) :
        (regAddr == OFS_DIGIN) ? digIn_q : '0;

    // read data and interrupt output
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= '0;
            irq <= 1'b0;
        end else begin
            regRdData <= regRdEn ? rdMux : '0;
            irq <= |((statSet | status_q) & mask_q);
        end
    end

    sequence seqNormStore;
        doneNorm && !goHold && !unread_q;
    endsequence
    sequence seqInjDone;
        doneInj && run_d;
    endsequence

    AST_SINGLE_STOPS: assert property (
        seqNormStore ##0 (mode == MODE_SGL_ONE) |=> ##1 !busy && !sampleEn)
        else $error("single conversion did not stop");
    AST_OVERRUN_FLAG: assert property (
        overrun && mask_q[ST_OVR] |=> status_q[ST_OVR] && irq)
        else $error("overrun not flagged");
    AST_HOLD_PAUSE: assert property (
        goHold |=> (state_q == ST_HOLD && !sampleEn && bufFull)
        until (state_q != ST_HOLD))
        else $error("conversion not paused while waiting");
    AST_READ_RELEASE: assert property (
        fromHold && !stopNow |=> ##1 sampleEn && unread_q)
        else $error("read did not release hold");
    AST_CONT_REPEAT: assert property (
        seqNormStore ##0 (mode == MODE_SGL_CONT) && run_d
        |=> ##1 sampleEn && muxSel == $past(chan_q, 2))
        else $error("continuous channel not repeated");
    AST_SCAN_STEP: assert property (
        loadRes && scanMode && chan_q != '0 && !stopNow
        |=> chan_q == $past(chan_q) - CH_W'(1))
        else $error("scan did not step down");
    AST_SCAN_WRAP: assert property (
        loadRes && mode == MODE_SCAN_CONT && chan_q == '0 && run_d
        |=> chan_q == $past(startChan) && state_q == ST_SAMPLE)
        else $error("continuous scan did not wrap");
    AST_STORE_REQ: assert property (
        loadRes |=> status_q[ST_DONE] && unread_q)
        else $error("stored result raised no request");
    AST_INJ_RESULT: assert property (
        doneInj |=> injResult_q[RES_W-1:0] == $past(convData)
        && status_q[ST_INJ])
        else $error("injection result not stored");
    AST_INJ_RESUME: assert property (
        seqInjDone |=> state_q == ST_SAMPLE && $stable(ctrl_q)
        ##1 muxSel == $past(chan_q))
        else $error("mode not resumed after injection");
    AST_BUSY_SPAN: assert property (
        (state_q == ST_IDLE) && wrCtl && regWrData[CTL_START_BIT]
        |=> busy [*2])
        else $error("busy not raised on start");
endmodule
`default_nettype wire

// File: dv/acs_ana_model.sv
// analog front end model: per-channel levels behind the input multiplexer
`timescale 1ns/1ps
`default_nettype none
module acs_ana_model
    import acs_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // converter side
    input wire logic [CH_W-1:0] muxSel,
    input wire logic sampleEn,
    input wire logic convEn,
    input wire logic [RES_W-1:0] levelBase,
    output logic [RES_W-1:0] convData
);
    logic [CH_W-1:0] heldCh = 4'h0;
    logic [RES_W-1:0] junk = 10'h155;
    // sample/hold freezes the channel; outside conversions the output toggles
    always @(posedge sys_clk) begin
        if (sampleEn) begin
            heldCh <= muxSel;
        end
        junk <= ~convData; // a stale level would hide late sampling
    end
    // each channel carries its own 10-bit level
    assign convData = convEn ?
        levelBase + RES_W'(heldCh) * 10'h025 : junk;
endmodule
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench of the conversion sequencer with analog model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import acs_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] regAddr = 3'h0;
    logic [DATA_W-1:0] regWrData = 16'h0000;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic [RES_W-1:0] convData;
    logic [RES_W-1:0] levelBase = 10'h000;
    logic [NUM_CH-1:0] anaDigIn = 16'h0000;
    logic [CH_W-1:0] muxSel;
    logic sampleEn, convEn, busy, irq;
    logic [DATA_W-1:0] rv;
    logic [3:0] ch;
    logic [1:0] cc, sc;
    int errors = 0;
    int check_count = 0;
    int seed = 55386;
    int n;
    int per;

    acs_seq_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .convData(convData), .anaDigIn(anaDigIn),
        .muxSel(muxSel), .sampleEn(sampleEn), .convEn(convEn), .busy(busy),
        .irq(irq));
    acs_ana_model model (.sys_clk(sys_clk), .muxSel(muxSel),
        .sampleEn(sampleEn), .convEn(convEn), .levelBase(levelBase),
        .convData(convData));

    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;

    // verdict and end of run, shared with the watchdog
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // compare seen against expected, count both outcomes
    task automatic chk(input string what, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // register port: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        #1 rv = regRdData;
    endtask

    // expected result word of a channel under the current levels
    function automatic logic [DATA_W-1:0] expRes(input logic [3:0] c);
        logic [RES_W-1:0] v;
        v = levelBase + RES_W'(c) * 10'h025;
        return {c, 2'b00, v};
    endfunction
    function automatic logic [DATA_W-1:0] ctl(input logic [1:0] cck, sck,
        input logic susp, wfr, input logic [1:0] mode, input logic [3:0] c);
        return {cck, sck, 3'b000, susp, wfr, 1'b1, mode, c};
    endfunction

    // length of a sample (sel 0) or convert (sel 1) phase, small tolerance
    task automatic phaseLen(input bit sel, input int exp, input string what);
        int c;
        c = 0;
        n = 0;
        while ((sel ? convEn : sampleEn) !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        while ((sel ? convEn : sampleEn) === 1'b1 && c < 9000) begin
            @(posedge sys_clk);
            c++;
        end
        chk(what, 16'((c >= exp - 1 && c <= exp + 2) ? exp : c), 16'(exp));
    endtask

    // wait for k conversions to finish, bounded
    task automatic waitConv(input int k);
        n = 0;
        repeat (k) begin
            while (convEn !== 1'b1 && n < 9000) begin
                @(posedge sys_clk);
                n++;
            end
            while (convEn === 1'b1 && n < 9000) begin
                @(posedge sys_clk);
                n++;
            end
        end
        repeat (4) @(posedge sys_clk);
        chk("convWait", 16'(n >= 9000), 16'h0000);
    endtask
    task automatic waitIdle();
        n = 0;
        while (busy !== 1'b0 && n < 9000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("busyEnd", 16'(busy), 16'h0000);
    endtask

    // watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        #(60000 * 5);
        errors++;
        $display("watchdog expired");
        complete_run();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(OFS_CTRL);
        chk("ctrlReset", rv, CTRL_RESET);
        rd(OFS_STATUS);
        chk("statReset", rv, 16'h0000);
        rd(3'h7);
        chk("unmapped", rv, 16'h0000);
        chk("outsReset", 16'({busy, irq, sampleEn, convEn}), 16'h0000);
        @(posedge sys_clk);
        anaDigIn <= 16'($random(seed));
        repeat (2) @(posedge sys_clk);
        rd(OFS_DIGIN);
        chk("digIn", rv, anaDigIn);
        $display("done reset and digital inputs");

        // single conversions over the legal clock codes, 01 left out
        for (int i = 0; i < 3; i++) begin
            cc = (i == 0) ? 2'b00 : 2'(i + 1);
            sc = 2'($random(seed));
            ch = 4'($random(seed));
            per = (cc == 2'b00) ? 24 : (cc == 2'b10) ? 96 : 48;
            levelBase <= 10'($random(seed));
            wr(OFS_MASK, (i == 1) ? 16'h0000 : 16'h0001);
            wr(OFS_CTRL, ctl(cc, sc, 1'b0, 1'b0, MODE_SGL_ONE, ch));
            phaseLen(1'b0, per << sc, "sampleLen");
            chk("muxSel", 16'(muxSel), 16'(ch));
            phaseLen(1'b1, per * 10, "convLen");
            waitIdle();
            rd(OFS_RESULT);
            chk("singleRes", rv, expRes(ch));
            rd(OFS_STATUS);
            chk("doneFlag", rv & 16'h0007, 16'h0001);
            chk("irqMask", 16'(irq), 16'(i != 1));
            wr(OFS_STATUS, 16'h0007);
            repeat (2) @(posedge sys_clk);
            chk("irqClear", 16'(irq), 16'h0000);
            chk("stopped", 16'({busy, sampleEn}), 16'h0000);
            $display("done single cc %0d sc %0d", cc, sc);
        end

        // scan with suspension: results held back until read
        levelBase <= 10'($random(seed));
        wr(OFS_CTRL, ctl(2'b00, 2'b00, 1'b1, 1'b0, MODE_SCAN_ONE, 4'h2));
        waitConv(2);
        chk("heldBusy", 16'({busy, convEn}), 16'h0002);
        rd(OFS_RESULT);
        chk("scanRes2", rv, expRes(4'h2));
        waitConv(1);
        rd(OFS_RESULT);
        chk("scanRes1", rv, expRes(4'h1));
        rd(OFS_RESULT);
        chk("scanRes0", rv, expRes(4'h0));
        waitIdle();
        rd(OFS_STATUS);
        chk("noOverrun", rv & 16'h0002, 16'h0000);
        wr(OFS_STATUS, 16'h0007);
        $display("done scan with suspension");

        // scan without hold: overrun flag and interrupt
        wr(OFS_MASK, 16'h0002);
        wr(OFS_CTRL, ctl(2'b00, 2'b00, 1'b0, 1'b0, MODE_SCAN_ONE, 4'h1));
        waitConv(2);
        waitIdle();
        rd(OFS_STATUS);
        chk("overrun", rv & 16'h0003, 16'h0003);
        chk("irqOvr", 16'(irq), 16'h0001);
        rd(OFS_RESULT);
        chk("lastRes", rv, expRes(4'h0));
        wr(OFS_STATUS, 16'h0007);
        $display("done overrun");

        // continuous single channel with wait-for-read
        ch = 4'($random(seed));
        wr(OFS_CTRL, ctl(2'b00, 2'b00, 1'b0, 1'b1, MODE_SGL_CONT, ch));
        waitConv(2);
        rd(OFS_CTRL);
        chk("busyBit", rv & 16'h0040, 16'h0040);
        chk("paused", 16'({sampleEn, convEn}), 16'h0000);
        rd(OFS_RESULT);
        chk("contRes", rv, expRes(ch));
        waitConv(1);
        rd(OFS_RESULT);
        chk("bufRes", rv, expRes(ch));
        wr(OFS_CTRL, ctl(2'b00, 2'b00, 1'b0, 1'b1, MODE_SGL_CONT, ch)
            & 16'hFFBF);
        rd(OFS_RESULT);
        rd(OFS_RESULT);
        waitIdle();
        $display("done wait-for-read");

        // injection refused while idle, then taken during a scan loop
        wr(OFS_INJCTL, 16'h0019);
        repeat (40) @(posedge sys_clk);
        chk("injIdle", 16'(busy), 16'h0000);
        levelBase <= 10'($random(seed));
        wr(OFS_CTRL, ctl(2'b00, 2'b00, 1'b0, 1'b0, MODE_SCAN_CONT, 4'h3));
        wr(OFS_INJCTL, 16'h0019);
        waitConv(3);
        rd(OFS_STATUS);
        chk("injDone", rv & 16'h0004, 16'h0004);
        rd(OFS_INJRES);
        chk("injRes", rv, expRes(4'h9));
        rd(OFS_CTRL);
        chk("modeKept", rv & 16'h0070, 16'h0070);
        waitConv(1);
        rd(OFS_RESULT);
        chk("scanAgain", 16'(rv[15:12] <= 4'h3), 16'h0001);
        chk("scanData", rv, expRes(rv[15:12]));
        // channel 0 then the wrap back to the start channel
        waitConv(2);
        rd(OFS_RESULT);
        chk("scanWrap", rv, expRes(4'h3));
        wr(OFS_CTRL, 16'h0033);
        waitIdle();
        $display("done injection");
        complete_run();
    end
endmodule
`default_nettype wire
